//--- src/led_indicator_timing_ctrl.sv
// Purpose: LED timer control, extra LED function and polarity, pin mapping.
// Assumes: Status inputs come from logic on clk_sys; no synchroniser needed.
// Notes:   nrst is the hardware reset; sw_rst keeps all register fields.
//
// Function
// [R01] Force-interrupt bit holds the interrupt output asserted.
// [R02] Stretch field sets minimum activity on time; 000 disables; reset 100.
// [R03] Each stretch code step doubles the window, 21 ms at code 001.
// [R04] Blink field picks 42, 84, 170, 340, 670 ms; reset 340 ms.
// [R05] Speed pulse on and off fields pick 84..670 ms; reset 170 ms.
// [R06] Upper mapping bit drives third LED pin with sixth LED function.
// [R07] Lower mapping bit drives second-index pin with fifth LED function.
// [R08] Sixth LED polarity picks high/low drive and tristate when off.
// [R09] Fifth LED polarity uses the same four drive encodings.
// [R10] Fifth LED dual mode makes sixth LED control field ineffective.
// [R11] Codes 0000-0010: receive, link with activity blink, link with rx blink.
// [R12] Codes 0011-0101: on activity, blink activity, on transmit.
// [R13] Codes 0110-0111: on full duplex, the latter blinking on collision.
// [R14] Codes 1000-1011 force off, on, high-z, blink; sixth 11xx reserved.
// [R15] Fifth LED codes 1100, 1101, 1111 select dual-LED modes.
// [R16] Dual modes mix colours by a 12.5 percent step percentage; only code 1111 mixes, 1100 and 1101 pick by speed.
// [R17] Fields take defaults on hardware reset and keep them on soft reset.
// [R18] Blink and stretch timing share one free-running prescaler.
`default_nettype none
module led_indicator_timing_ctrl #(
  parameter int unsigned TICK_CYC = led_ind_pkg::TICK_CYC
) (
  // Clock and resets
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 sw_rst,
  // Register port
  input  wire logic [4:0]           addr,
  input  wire logic [15:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [15:0]          rdata,
  // Link status and mix percentage
  input  wire led_ind_pkg::status_t st,
  input  wire logic [3:0]           mix_pct,
  // Interrupt
  input  wire logic                 irq_req,
  output logic                      irq_n,
  // Own drive of the third and second-index pins
  input  wire led_ind_pkg::pin_t    led3_own,
  input  wire led_ind_pkg::pin_t    led2_own,
  // Pins
  output led_ind_pkg::pin_t         led5_pin,
  output led_ind_pkg::pin_t         led4_pin,
  output led_ind_pkg::pin_t         led3_pin,
  output led_ind_pkg::pin_t         led2_pin,
  output logic                      speed_pulse
);
  led_ind_pkg::main_st_t q, d;
  led_ind_pkg::pin_t     drv5, drv4;
  logic [2:0]            raw, strd;
  logic [2:0]            str_code;
  logic [3:0]            ctl5, ctl4, pct;
  logic [1:0]            pol5, pol4, fn5, fn4, spd_cnt;
  logic                  ms_tick, blink, mix_on, dual;
  logic                  on5, on4, hiz5, hiz4;

  // Field views
  assign str_code = q.timer[led_ind_pkg::STRETCH_LSB +: 3];
  assign ctl5     = q.func[led_ind_pkg::CTL5_LSB +: 4];
  assign ctl4     = q.func[led_ind_pkg::CTL4_LSB +: 4];
  assign pol5     = q.func[led_ind_pkg::POL5_LSB +: 2];
  assign pol4     = q.func[led_ind_pkg::POL4_LSB +: 2];
  // [R10] dual mode detection
  assign dual     = (ctl4[3:2] == 2'h3);

  // Speed blink count: 1, 2, 3 for 10, 100, 1000 Mbps, 0 without link
  assign spd_cnt = (!st.link || st.spd == 2'h3) ? 2'h0 : st.spd + 2'h1;

  // [R18] shared prescaler, blink and speed timing
  led_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .sw_rst       (sw_rst),
    .blink_code   (q.timer[led_ind_pkg::BLINK_LSB +: 3]),
    .spd_on_code  (q.timer[led_ind_pkg::SPD_ON_LSB +: 2]),
    .spd_off_code (q.timer[led_ind_pkg::SPD_OFF_LSB +: 2]),
    .spd_count    (spd_cnt),
    .ms_tick      (ms_tick),
    .blink        (blink),
    .speed_pulse  (speed_pulse)
  );

  // Activity kinds that are stretched: activity, receive, transmit
  assign raw = {st.tx, st.rx, st.act};
  // [R02] stretched indication is raw or window still running
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      strd[i] = raw[i] | (q.str_cnt[i] != 11'h000);
    end
  end

  // [R16] reserved percentages above full scale act as full scale
  assign pct    = (mix_pct > led_ind_pkg::MIX_FULL) ? led_ind_pkg::MIX_FULL : mix_pct;
  assign mix_on = ({1'b0, q.pwm} < pct);

  // Single LED function: returns {hiz, on}
  function automatic logic [1:0] led_fn(input logic [3:0] c,
                                        input logic [2:0] s,
                                        input led_ind_pkg::status_t t,
                                        input logic bl);
    logic [1:0] r;
    r = 2'h0;
    case (c)
      // [R11] receive and link based codes
      4'h0: r[0] = s[1];
      4'h1: r[0] = t.link & (s[0] ? bl : 1'b1);
      4'h2: r[0] = t.link & (s[1] ? bl : 1'b1);
      // [R12] activity and transmit codes
      4'h3: r[0] = s[0];
      4'h4: r[0] = s[0] & bl;
      4'h5: r[0] = s[2];
      // [R13] duplex codes
      4'h6: r[0] = t.link & t.fdx;
      4'h7: r[0] = t.link & t.fdx & (t.col ? bl : 1'b1);
      // [R14] forced states
      4'h8: r[0] = 1'b0;
      4'h9: r[0] = 1'b1;
      4'ha: r[1] = 1'b1;
      4'hb: r[0] = bl;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // [R15] dual modes: returns {on5, on4}
  function automatic logic [1:0] dual_fn(input logic [3:0] c,
                                         input logic act_s,
                                         input led_ind_pkg::status_t t,
                                         input logic bl,
                                         input logic mx);
    logic [1:0] r;
    logic       g;
    logic       gig;
    r   = 2'h0;
    gig = (t.spd == 2'h2);
    g   = t.link & (act_s ? bl : 1'b1);
    case (c)
      4'hc: r = {t.link & ~gig, t.link & gig};
      4'hd: r = {g & ~gig, g & gig};
      // [R16] colour mix from the percentage
      4'hf: r = {g & ~mx, g & mx};
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // LED function decode
  always_comb begin
    fn4  = led_fn(ctl4, strd, st, blink);
    fn5  = led_fn((ctl5[3:2] == 2'h3) ? 4'hf : ctl5, strd, st, blink);
    hiz4 = fn4[1] & ~dual;
    hiz5 = fn5[1] & ~dual;
    on4  = fn4[0];
    on5  = fn5[0];
    // [R10] sixth LED follows the dual mode, not its own field
    if (dual) begin
      {on5, on4} = dual_fn(ctl4, strd[0], st, blink, mix_on);
    end
  end

  // [R08] sixth LED drive
  led_pin_drv u_drv5 (
    .on  (on5),
    .hiz (hiz5),
    .pol (pol5),
    .pin (drv5)
  );

  // [R09] fifth LED drive
  led_pin_drv u_drv4 (
    .on  (on4),
    .hiz (hiz4),
    .pol (pol4),
    .pin (drv4)
  );

  // Next state: registers, read data, stretch windows, pins
  always_comb begin
    d       = q;
    d.rdata = 16'h0000;
    // [R17] writes only; soft reset leaves the fields alone
    if (wr && addr == led_ind_pkg::OFF_TIMER) begin
      d.timer = wdata;
    end
    if (wr && addr == led_ind_pkg::OFF_FUNC) begin
      d.func = wdata;
    end
    // Read data stands one cycle; unmapped reads return zero
    if (rd) begin
      case (addr)
        led_ind_pkg::OFF_TIMER: d.rdata = q.timer;
        led_ind_pkg::OFF_FUNC:  d.rdata = q.func;
        default:                d.rdata = 16'h0000;
      endcase
    end
    // [R01] forced interrupt overrides normal requests
    d.irq_n = ~(q.timer[led_ind_pkg::FORCE_INT_BIT] | irq_req);
    // [R03] window doubles with each code step
    for (int i = 0; i < 3; i++) begin
      if (raw[i] && str_code != 3'h0) begin
        d.str_cnt[i] = 11'(led_ind_pkg::STRETCH_BASE_MS << (str_code - 3'h1));
      end else if (str_code == 3'h0) begin
        d.str_cnt[i] = 11'h000;
      end else if (ms_tick && q.str_cnt[i] != 11'h000) begin
        d.str_cnt[i] = q.str_cnt[i] - 11'h001;
      end
    end
    // Mix PWM runs every clock, eight slots of 12.5 percent
    d.pwm  = q.pwm + 3'h1;
    d.led5 = drv5;
    d.led4 = drv4;
    // [R06] third pin mapping
    d.led3 = q.func[led_ind_pkg::MAP3_BIT] ? drv5 : led3_own;
    // [R07] second-index pin mapping
    d.led2 = q.func[led_ind_pkg::MAP2_BIT] ? drv4 : led2_own;
    // Soft reset clears transient state only
    if (sw_rst) begin
      d.str_cnt = '0;
      d.pwm     = 3'h0;
    end
  end

  // [R17] hardware reset loads the defaults
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q       <= '0;
      q.timer <= led_ind_pkg::TIMER_RST;
      q.func  <= led_ind_pkg::FUNC_RST;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rdata    = q.rdata;
  assign irq_n    = q.irq_n;
  assign led5_pin = q.led5;
  assign led4_pin = q.led4;
  assign led3_pin = q.led3;
  assign led2_pin = q.led2;

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_force_int_hold: assert property ( // [R01]
    q.timer[led_ind_pkg::FORCE_INT_BIT] |=> !irq_n)
    else $error("forced interrupt not asserted");
  a_stretch_load: assert property ( // [R03]
    st.act && str_code == 3'h3 && !sw_rst |=> q.str_cnt[0] == 11'h054)
    else $error("stretch window wrong length");
  a_stretch_off: assert property ( // [R02]
    str_code == 3'h0 && !(wr && addr == led_ind_pkg::OFF_TIMER) |=> q.str_cnt[0] == 11'h000)
    else $error("stretch active while disabled");
  a_map_pin3: assert property ( // [R06]
    q.func[led_ind_pkg::MAP3_BIT] |=> led3_pin == led5_pin)
    else $error("third pin not mapped to sixth LED");
  a_map_pin2: assert property ( // [R07]
    q.func[led_ind_pkg::MAP2_BIT] |=> led2_pin == led4_pin)
    else $error("second pin not mapped to fifth LED");
  a_force_off_pol: assert property ( // [R08]
    !dual && ctl5 == 4'h8 && pol5 == 2'h0 |=> led5_pin.o && led5_pin.oe)
    else $error("sixth LED off level wrong");
  a_tristate_off: assert property ( // [R09]
    ctl4 == 4'h8 && pol4[1] |=> !led4_pin.oe)
    else $error("fifth LED not tristated when off");
  a_force_hiz: assert property ( // [R14]
    ctl4 == 4'ha |=> !led4_pin.oe ##0 !led4_pin.o)
    else $error("fifth LED not high impedance");
  a_dual_ignore: assert property ( // [R10]
    ctl4 == 4'he && ctl5 == 4'h9 && pol5 == 2'h1 |=> led5_pin.oe && !led5_pin.o)
    else $error("sixth LED field acted in dual mode");
  a_read_timer: assert property ( // [R04]
    rd && addr == led_ind_pkg::OFF_TIMER |=> rdata == $past(q.timer))
    else $error("timer register read wrong");
  a_soft_keep: assert property ( // [R17]
    sw_rst && !wr |=> $stable(q.timer) && $stable(q.func))
    else $error("soft reset changed a field");
  a_rdata_idle: assert property (
    !rd |=> rdata == 16'h0000)
    else $error("read data outside its slot");
  a_mix_full: assert property ( // [R16]
    ctl4 == 4'hf && mix_pct == 4'h8 && st.link && !st.act && !strd[0]
    && pol4 == 2'h1 |=> led4_pin.o)
    else $error("full mix did not light fifth LED");

  c_dual_mix: cover property (ctl4 == 4'hf && mix_on ##1 !mix_on);
  c_map_both: cover property (q.func[led_ind_pkg::MAP3_BIT] && q.func[led_ind_pkg::MAP2_BIT]);
  c_stretch_run: cover property (!st.act && q.str_cnt[0] != 11'h000);
  c_force_int: cover property (q.timer[led_ind_pkg::FORCE_INT_BIT] && !irq_req ##1 !irq_n);
endmodule
`default_nettype wire

//--- src/led_ind_pkg.sv
// Purpose: Shared constants and types of the extra LED and LED timer block.
// Assumes: Core clock of 250 MHz; registers are 16 bits wide.
// Notes:   Register offsets are the printed ones, used directly as addresses.
`default_nettype none
package led_ind_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam logic [10:0] STRETCH_BASE_MS = 11'h015;
  // Periods in ms for codes 0..4 (42, 84, 170, 340, 670)
  localparam logic [4:0][9:0] PERIOD_MS = {10'h29e, 10'h154, 10'h0aa, 10'h054, 10'h02a};

  // Register offsets and reset values
  localparam logic [4:0]  OFF_TIMER = 5'h12;
  localparam logic [4:0]  OFF_FUNC  = 5'h13;
  localparam logic [15:0] TIMER_RST = 16'h4b05;
  localparam logic [15:0] FUNC_RST  = 16'h0073;

  // Field positions, timer control register
  localparam int FORCE_INT_BIT = 15;
  localparam int STRETCH_LSB   = 12;
  localparam int BLINK_LSB     = 8;
  localparam int SPD_OFF_LSB   = 2;
  localparam int SPD_ON_LSB    = 0;
  // Field positions, extra LED register
  localparam int MAP3_BIT = 15;
  localparam int MAP2_BIT = 14;
  localparam int POL5_LSB = 10;
  localparam int POL4_LSB = 8;
  localparam int CTL5_LSB = 4;
  localparam int CTL4_LSB = 0;

  // Mix percentage full scale (100 %)
  localparam logic [3:0] MIX_FULL = 4'h8;

  // Link status seen by the indicators
  typedef struct packed {
    logic       link;
    logic       act;
    logic       rx;
    logic       tx;
    logic       fdx;
    logic       col;
    logic [1:0] spd;
  } status_t;

  // Pin as output value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } pin_t;

  typedef enum logic [1:0] {SP_GAP, SP_ON, SP_OFF} sp_state_t;

  typedef struct packed {
    logic [19:0] pre;
    logic        tick;
    logic [9:0]  bl_cnt;
    logic        bl_ph;
    sp_state_t   sp;
    logic [9:0]  sp_cnt;
    logic [1:0]  sp_left;
  } tick_st_t;

  typedef struct packed {
    logic [15:0]      timer;
    logic [15:0]      func;
    logic [15:0]      rdata;
    logic             irq_n;
    logic [2:0][10:0] str_cnt;
    logic [2:0]       pwm;
    pin_t             led5;
    pin_t             led4;
    pin_t             led3;
    pin_t             led2;
  } main_st_t;
endpackage
`default_nettype wire

//--- src/led_pin_drv.sv
// Purpose: Turns an on/off indication into pin value and enable.
// Assumes: Polarity codes as in the extra LED register.
// Notes:   Purely combinational; the caller registers the result.
`default_nettype none
module led_pin_drv (
  // Indication
  input  wire logic              on,
  input  wire logic              hiz,
  input  wire logic [1:0]        pol,
  // Pin
  output led_ind_pkg::pin_t      pin
);
  // Pol[1] tristates when off, pol[0] is the level when on
  always_comb begin
    pin.o  = 1'b0;
    pin.oe = 1'b0;
    if (!hiz) begin
      if (on) begin
        pin.o  = pol[0];
        pin.oe = 1'b1;
      end else if (!pol[1]) begin
        pin.o  = ~pol[0];
        pin.oe = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/led_tick_gen.sv
// Purpose: Shared ms prescaler, blink square wave and speed pulse train.
// Assumes: One instance per port so every LED blinks in phase.
// Notes:   Period changes take effect at the next compare.
`default_nettype none
module led_tick_gen #(
  parameter int unsigned TICK_CYC = led_ind_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       sw_rst,
  // Settings
  input  wire logic [2:0] blink_code,
  input  wire logic [1:0] spd_on_code,
  input  wire logic [1:0] spd_off_code,
  input  wire logic [1:0] spd_count,
  // Outputs
  output logic            ms_tick,
  output logic            blink,
  output logic            speed_pulse
);
  led_ind_pkg::tick_st_t q, d;
  logic [9:0] half;

  // [R04] blink half period; reserved codes fall back to the slowest rate
  assign half = (blink_code > 3'h4) ? (led_ind_pkg::PERIOD_MS[4] >> 1)
                                    : (led_ind_pkg::PERIOD_MS[blink_code] >> 1);

  // Next state
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.pre >= 20'(TICK_CYC - 1)) begin
      d.pre  = '0;
      d.tick = 1'b1;
    end else begin
      d.pre = q.pre + 20'h00001;
    end
    // Blink half-period count
    if (q.tick) begin
      if (q.bl_cnt >= half - 10'h001) begin
        d.bl_cnt = '0;
        d.bl_ph  = ~q.bl_ph;
      end else begin
        d.bl_cnt = q.bl_cnt + 10'h001;
      end
    end
    // [R05] speed pulse train: gap, then on/off pairs
    // Index widened to 3 bits so code 11 reaches 670 ms instead of wrapping
    if (q.tick) begin
      d.sp_cnt = q.sp_cnt + 10'h001;
      case (q.sp)
        led_ind_pkg::SP_GAP: begin
          if (q.sp_cnt >= led_ind_pkg::PERIOD_MS[3'(spd_off_code) + 3'h1] - 10'h001) begin
            d.sp_cnt  = '0;
            d.sp_left = spd_count;
            if (spd_count != 2'h0) begin
              d.sp = led_ind_pkg::SP_ON;
            end
          end
        end
        led_ind_pkg::SP_ON: begin
          if (q.sp_cnt >= led_ind_pkg::PERIOD_MS[3'(spd_on_code) + 3'h1] - 10'h001) begin
            d.sp_cnt  = '0;
            d.sp_left = q.sp_left - 2'h1;
            d.sp      = led_ind_pkg::SP_OFF;
          end
        end
        led_ind_pkg::SP_OFF: begin
          if (q.sp_cnt >= led_ind_pkg::PERIOD_MS[3'(spd_off_code) + 3'h1] - 10'h001) begin
            d.sp_cnt = '0;
            d.sp     = (q.sp_left == 2'h0) ? led_ind_pkg::SP_GAP : led_ind_pkg::SP_ON;
          end
        end
        default: d.sp = led_ind_pkg::SP_GAP;
      endcase
    end
    if (sw_rst) begin
      d = '0;
    end
  end

  // State register; reset restarts the shared phase
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ms_tick     = q.tick;
  assign blink       = q.bl_ph;
  assign speed_pulse = (q.sp == led_ind_pkg::SP_ON);

  // [R04] blink phase toggles
  a_blink_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)
    q.tick && !sw_rst && q.bl_cnt >= half - 10'h001 |=> blink != $past(blink)) // [R04]
    else $error("blink phase did not toggle");
  // [R18] prescaler period
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!nrst)
    q.tick && TICK_CYC > 1 |=> !q.tick) // [R18]
    else $error("ms tick repeated too soon");
  c_speed_train: cover property (@(posedge clk_sys) disable iff (!nrst)
    q.sp == led_ind_pkg::SP_OFF ##1 q.sp == led_ind_pkg::SP_ON);
endmodule
`default_nettype wire

//--- sim/led_lamp.sv
// Purpose: External indicator lamp hanging on one LED pin.
// Assumes: An undriven pin settles to the level of its pull resistor.
// Notes:   Never keeps the last driven value once the pin is released.
`default_nettype none
module led_lamp #(
  parameter logic PULL    = 1'b0,
  parameter logic LIT_LVL = 1'b1
) (
  // Pin from the block
  input  wire led_ind_pkg::pin_t pin,
  // Observed lamp
  output logic                   lvl,
  output logic                   lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin goes to the pull level, not to a stale value
  assign lvl = pin.oe ? pin.o : PULL;
  assign lit = (lvl == LIT_LVL);
endmodule
`default_nettype wire

//--- sim/tb_led_indicator_timing_ctrl.sv
// Purpose: Self-checking bench of the LED timer and extra LED block.
// Assumes: Prescaler shortened to 4 clocks per ms tick.
// Notes:   Row table covers steady decodes; timing cases are hand-written.
`default_nettype none
module tb_led_indicator_timing_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned T = 4;
  localparam int LIMIT = 80000;
  // Rows: func, status, mix, expected led5 and led4 pins {o,oe}
  localparam logic [31:0] ROWS [23] = '{
    32'h0500_20_0_f, 32'h0500_00_0_5, 32'h0511_80_0_f, 32'h0522_80_0_f,
    32'h0522_00_0_5, 32'h0533_40_0_f, 32'h0544_00_0_5, 32'h0555_10_0_f,
    32'h0555_20_0_5, 32'h0566_88_0_f, 32'h0566_80_0_5, 32'h0577_88_0_f,
    32'h0589_00_0_7, 32'h05aa_00_0_0, 32'h0098_00_0_7, 32'h0f98_00_0_c,
    32'h0a98_00_0_4, 32'h0b89_00_0_3, 32'h053c_82_0_7, 32'h053c_81_0_d,
    32'h059d_82_0_7, 32'h059f_82_8_7, 32'h059f_82_0_d};
  localparam int BL_MS [6] = '{42, 84, 170, 340, 670, 670};
  localparam int SP_MS [4] = '{84, 170, 340, 670};
  localparam int SK [3] = '{0, 1, 3};

  logic                 clk_sys;
  logic                 nrst;
  logic                 sw_rst;
  logic [4:0]           addr;
  logic [15:0]          wdata;
  logic                 wr;
  logic                 rd;
  logic [15:0]          rdata;
  led_ind_pkg::status_t st;
  logic [3:0]           mix_pct;
  logic                 irq_req;
  logic                 irq_n;
  led_ind_pkg::pin_t    led3_own;
  led_ind_pkg::pin_t    led2_own;
  led_ind_pkg::pin_t    led5_pin;
  led_ind_pkg::pin_t    led4_pin;
  led_ind_pkg::pin_t    led3_pin;
  led_ind_pkg::pin_t    led2_pin;
  logic                 speed_pulse;
  logic                 sel;
  logic                 probe;
  logic                 lamp_lvl;
  logic                 lamp_lit;
  int                   n_errors;
  int                   tests_run;
  int                   cyc;

  led_indicator_timing_ctrl #(.TICK_CYC(T)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .sw_rst(sw_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .st(st), .mix_pct(mix_pct), .irq_req(irq_req),
    .irq_n(irq_n), .led3_own(led3_own), .led2_own(led2_own), .led5_pin(led5_pin),
    .led4_pin(led4_pin), .led3_pin(led3_pin), .led2_pin(led2_pin),
    .speed_pulse(speed_pulse));

  // Active-high lamp on the fifth LED pin, pulled low
  led_lamp #(.PULL(1'b0), .LIT_LVL(1'b1)) lamp4 (.pin(led4_pin), .lvl(lamp_lvl), .lit(lamp_lit));

  // Timing probe: speed pulse or LED4 pin value
  assign probe = sel ? speed_pulse : led4_pin.o;

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Write: one strobe cycle, then one idle edge so strobes never collide
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read: data stands only in the cycle after the strobe, then zero
  task automatic rreg(input logic [4:0] a, input logic [15:0] exp, input string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check(nm, rdata, exp);
    @(negedge clk_sys);
    check("rdata idle", rdata, 16'h0000);
    @(posedge clk_sys);
  endtask

  // Cycles until the probe changes, bounded
  task automatic wait_chg(output int n);
    logic v;
    n = 0;
    v = probe;
    do begin
      @(negedge clk_sys);
      n++;
    end while (probe === v && n < 3000);
  endtask

  // Length of the next high phase of the probe
  task automatic rise_len(output int len);
    int k;
    k = 0;
    while (probe !== 1'b1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    wait_chg(len);
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r;
    int          n;
    int          e;
    int          tol;
    nrst = 1'b0;
    sw_rst = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    st = '0;
    mix_pct = 4'h0;
    irq_req = 1'b0;
    led3_own = 2'b10;
    led2_own = 2'b10;
    sel = 1'b0;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // Defaults, read-write access, unmapped place, soft and hard reset
    rreg(5'h12, 16'h4b05, "timer reset");
    rreg(5'h13, 16'h0073, "func reset");
    wreg(5'h05, 16'hffff);
    rreg(5'h05, 16'h0000, "unmapped");
    wreg(5'h12, 16'h3a5a);
    wreg(5'h13, 16'hc5a5);
    sw_rst <= 1'b1;
    @(posedge clk_sys);
    sw_rst <= 1'b0;
    rreg(5'h12, 16'h3a5a, "timer kept");
    rreg(5'h13, 16'hc5a5, "func kept");
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rreg(5'h12, 16'h4b05, "timer rehw");
    $display("test registers done");
    // Interrupt forcing
    repeat (2) @(negedge clk_sys);
    check("irq idle", 16'(irq_n), 16'h0001);
    wreg(5'h12, 16'h8b05);
    @(negedge clk_sys);
    check("irq forced", 16'(irq_n), 16'h0000);
    wreg(5'h12, 16'h0b05);
    @(negedge clk_sys);
    check("irq released", 16'(irq_n), 16'h0001);
    irq_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("irq normal", 16'(irq_n), 16'h0000);
    irq_req <= 1'b0;
    $display("test interrupt done");
    // Steady decode table, stretching off
    for (int i = 0; i < 23; i++) begin
      r = ROWS[i];
      wreg(5'h13, r[31:16]);
      st <= r[15:8];
      mix_pct <= r[7:4];
      repeat (3) @(negedge clk_sys);
      check("led5", 16'(led5_pin), 16'(r[3:2]));
      check("led4", 16'(led4_pin), 16'(r[1:0]));
      @(posedge clk_sys);
    end
    $display("test decode table done");
    // Colour mix share over whole PWM frames
    foreach (SK[j]) begin
      wreg(5'h13, 16'h059f);
      st <= 8'h82;
      mix_pct <= (j == 0) ? 4'h4 : 4'h9;
      repeat (4) @(negedge clk_sys);
      n = 0;
      repeat (64) begin
        @(negedge clk_sys);
        n += (led4_pin.o === 1'b1);
      end
      check("mix", 16'(n), (j == 0) ? 16'h0020 : 16'h0040);
    end
    $display("test mix done");
    // Pin mapping and the lamp
    wreg(5'h13, 16'hc589);
    st <= '0;
    repeat (2) @(negedge clk_sys);
    check("map3", 16'(led3_pin), 16'h0001);
    check("map2", 16'(led2_pin), 16'h0003);
    check("lamp", 16'(lamp_lit), 16'h0001);
    check("lamp lvl", 16'(lamp_lvl), 16'h0001);
    wreg(5'h13, 16'h0589);
    @(negedge clk_sys);
    check("own3", 16'(led3_pin), 16'h0002);
    check("own2", 16'(led2_pin), 16'h0002);
    $display("test mapping done");
    // Blink half periods, both LEDs in step
    wreg(5'h13, 16'h05bb);
    for (int c = 0; c < 6; c++) begin
      wreg(5'h12, {5'b00001, 3'(c), 8'h05});
      wait_chg(n);
      wait_chg(n);
      wait_chg(n);
      check("blink", 16'(n), 16'(BL_MS[c] / 2 * T));
      check("phase", 16'(led5_pin.o), 16'(led4_pin.o));
    end
    $display("test blink done");
    // Stretch of a one-cycle activity pulse
    wreg(5'h13, 16'h0503);
    foreach (SK[j]) begin
      wreg(5'h12, {1'b0, 3'(SK[j]), 1'b1, 3'h3, 8'h05});
      st.act <= 1'b1;
      @(posedge clk_sys);
      st.act <= 1'b0;
      rise_len(n);
      e = (SK[j] == 0) ? 1 : (21 << (SK[j] - 1)) * T;
      tol = (SK[j] == 0) ? 0 : T + 2;
      check("stretch", 16'(n >= e - tol && n <= e + tol), 16'h0001);
    end
    $display("test stretch done");
    // Speed pulse on periods at 10M link
    sel <= 1'b1;
    st <= 8'h80;
    for (int c = 0; c < 4; c++) begin
      wreg(5'h12, {8'h0b, 6'h00, 2'(c)});
      rise_len(n);
      rise_len(n);
      e = SP_MS[c] * T;
      check("spd on", 16'(n >= e - T && n <= e + T), 16'h0001);
    end
    $display("test speed pulse done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
